// ==== inc/ext_mem_params.svh ====
// Constants for the external memory interface: offsets, fields, reset values, address map.
`ifndef EXT_MEM_PARAMS_SVH
`define EXT_MEM_PARAMS_SVH

// =====================================================================
// APB register offsets (byte addresses).
`define EMI_OFF_PINOPT   12'h000
`define EMI_OFF_WAIT     12'h004
`define EMI_OFF_STATUS   12'h008

// =====================================================================
// Pin option register fields.
`define EMI_PO_ROM_DLY   0
`define EMI_PO_RAM_DLY   1
`define EMI_PO_IO_DLY    2
`define EMI_PO_RW_ADV    3
`define EMI_PO_WD_DLY    10
`define EMI_PO_WIDTH     11
`define EMI_PO_RESET     11'h000

// =====================================================================
// Wait-state register: four 4-bit fields, segment index times four.
`define EMI_WS_FIELD_W   4
`define EMI_WAIT_RESET   16'hffff
`define EMI_WS_READY_MIN 4'h4

// =====================================================================
// Status register fields.
`define EMI_ST_BOOT      0
`define EMI_ST_BUSY      1

// =====================================================================
// Y-space map on address bits [15:14]; X space always maps to the ROM segment.
`define EMI_MAP_ROM      2'h0
`define EMI_MAP_IO       2'h1
`define EMI_MAP_RAMLO    2'h2
`define EMI_MAP_RAMHI    2'h3

// Edges after reset release that the boot synchroniser needs before it holds a pin sample.
`define EMI_BOOT_SETTLE  2'h2

// Extra edges after an access so the data synchroniser delivers the last access sample.
`define EMI_SYNC_TAIL    4'h1

`endif

// ==== inc/ext_mem_pkg.sv ====
// Types for the external memory interface.
`default_nettype none
package ext_mem_pkg;

   typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_ACCESS, ST_TAIL} accState_t;

   typedef enum logic [1:0] {SEG_ROM, SEG_RAMHI, SEG_RAMLO, SEG_IO} seg_t;

   typedef struct packed {
      accState_t   state;
      seg_t        seg;
      logic [3:0]  cnt;
      logic [3:0]  ws;
      logic        accWrite;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic        done;
      logic [10:0] pinOpt;
      logic [15:0] waitReg;
      logic [31:0] prdata;
      logic        pslverr;
      logic        readySync1;
      logic        readySync2;
      logic        bootSync1;
      logic        bootSync2;
      logic [1:0]  bootCnt;
      logic        boot;
      logic [15:0] dataSync1;
      logic [15:0] dataSync2;
   } emiState_t;

endpackage
`default_nettype wire

// ==== hdl/external_memory_interface.sv ====
// External memory interface: segment decode, wait states, ready stretch, APB registers.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ext_mem_params.svh"
// What this block does
// - Serves X and Y reads and writes.
// - Four segments, each with wait field.
// - Address holds last external access value.
// - Bidirectional data; write drive delay option.
// - Boot pin caught at reset release.
// - Read-not-write output; advance option.
// - ROM select for X or Y; delay option.
// - Upper RAM select on Y only; delay.
// - Lower RAM select on Y only; delay.
// - I/O select on data space; delay.
// - Combined RAM select for either RAM.
// - Ready input stretches beyond the programmed wait states.
// - Ready input synchronised before use.
// - Stretch by cycles ready stays asserted.
// - Ready ignored unless wait field four+.
// - Pin option register cleared by reset.
module external_memory_interface (
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Core access port.
   input  wire logic        coreReq,
   input  wire logic        coreSpaceY,
   input  wire logic        coreWrite,
   input  wire logic [15:0] coreAddr,
   input  wire logic [15:0] coreWdata,
   output logic             coreReady,
   output logic             coreDone,
   output logic [15:0]      coreRdata,
   output logic             bootFromExtRom,
   // External memory pins.
   output logic [15:0]      ext_addr_out,
   input  wire logic [15:0] extDataIn,
   output logic [15:0]      extDataOut,
   output logic             extDataOe,
   output logic             read_not_write,
   output logic             ext_rom_select_n,
   output logic             upper_ram_select_n,
   output logic             lower_ram_select_n,
   output logic             periphSelect_n,
   output logic             any_ram_select_n,
   input  wire logic        readyIn_n,
   input  wire logic        boot_source_select
);

   ext_mem_pkg::emiState_t r;
   ext_mem_pkg::emiState_t next_r;

   logic readyAct;
   logic inLead;
   logic inAccess;
   logic selDelay;
   logic selOn;

   // =====================================================================
   // Decode helpers.

   // Fixed map: X goes to ROM, Y splits on the top two address bits.
   function automatic ext_mem_pkg::seg_t decodeSeg(input logic spaceY, input logic [15:0] a);
      ext_mem_pkg::seg_t s;
      s = ext_mem_pkg::SEG_ROM;
      if (spaceY) begin
         case (a[15:14])
            `EMI_MAP_IO:    s = ext_mem_pkg::SEG_IO;
            `EMI_MAP_RAMLO: s = ext_mem_pkg::SEG_RAMLO;
            `EMI_MAP_RAMHI: s = ext_mem_pkg::SEG_RAMHI;
            default:        s = ext_mem_pkg::SEG_ROM;
         endcase
      end
      return s;
   endfunction

   // Picks the wait field of a segment.
   function automatic logic [3:0] waitOf(input logic [15:0] w, input ext_mem_pkg::seg_t s);
      return w[{s, 2'b00} +: `EMI_WS_FIELD_W];
   endfunction

   // =====================================================================
   // Next-state logic.
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      // Pin synchronisers: first stage feeds only the second.
      next_r.readySync1 = readyIn_n;
      next_r.readySync2 = r.readySync1;
      next_r.bootSync1  = boot_source_select;
      next_r.bootSync2  = r.bootSync1;
      next_r.dataSync1  = extDataIn;
      next_r.dataSync2  = r.dataSync1;
      // Boot pin is caught once the synchroniser holds post-release samples; reset
      // cleared both stages, so the first edges after release carry no pin value.
      if (r.bootCnt != `EMI_BOOT_SETTLE + 2'h1) begin
         next_r.bootCnt = r.bootCnt + 2'h1;
         if (r.bootCnt == `EMI_BOOT_SETTLE) begin
            next_r.boot = r.bootSync2;
         end
      end
      // Access sequencer.
      case (r.state)
         ext_mem_pkg::ST_IDLE: begin
            if (coreReq) begin
               next_r.state    = ext_mem_pkg::ST_LEAD;
               next_r.seg      = decodeSeg(coreSpaceY, coreAddr);
               next_r.ws       = waitOf(r.waitReg, decodeSeg(coreSpaceY, coreAddr));
               next_r.addr     = coreAddr;
               next_r.wdata    = coreWdata;
               next_r.accWrite = coreWrite;
            end
         end
         ext_mem_pkg::ST_LEAD: begin
            next_r.state = ext_mem_pkg::ST_ACCESS;
            next_r.cnt   = r.ws;
         end
         ext_mem_pkg::ST_ACCESS: begin
            if (r.cnt != 4'h0) begin
               next_r.cnt = r.cnt - 4'h1;
            end else if (!(readyAct && r.ws >= `EMI_WS_READY_MIN)) begin
               next_r.state = ext_mem_pkg::ST_TAIL;
               next_r.cnt   = `EMI_SYNC_TAIL;
            end
         end
         // The pins seen at the last access edge need two more edges through the
         // synchroniser; without this tail a short read would return idle-bus noise.
         ext_mem_pkg::ST_TAIL: begin
            if (r.cnt != 4'h0) begin
               next_r.cnt = r.cnt - 4'h1;
            end else begin
               next_r.state = ext_mem_pkg::ST_IDLE;
               next_r.done  = 1'b1;
               if (!r.accWrite) begin
                  next_r.rdata = r.dataSync2;
               end
            end
         end
         default: next_r.state = ext_mem_pkg::ST_IDLE;
      endcase
      // APB: read data is staged in the setup cycle so the access phase answers at once.
      if (psel && !penable) begin
         next_r.prdata  = 32'h0000_0000;
         next_r.pslverr = 1'b0;
         case (paddr)
            `EMI_OFF_PINOPT: next_r.prdata[10:0] = r.pinOpt;
            `EMI_OFF_WAIT:   next_r.prdata[15:0] = r.waitReg;
            `EMI_OFF_STATUS: begin
               next_r.prdata[`EMI_ST_BOOT] = r.boot;
               next_r.prdata[`EMI_ST_BUSY] = r.state != ext_mem_pkg::ST_IDLE;
            end
            default: next_r.pslverr = 1'b1;
         endcase
      end
      // Writes land at the access edge; a mid-access wait change only affects later accesses.
      if (psel && penable && pwrite) begin
         if (paddr == `EMI_OFF_PINOPT) begin
            next_r.pinOpt = pwdata[10:0];
         end
         if (paddr == `EMI_OFF_WAIT) begin
            next_r.waitReg = pwdata[15:0];
         end
      end
   end

   // =====================================================================
   // State register.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r         <= '0;
         r.state   <= ext_mem_pkg::ST_IDLE;
         r.pinOpt  <= `EMI_PO_RESET;
         r.waitReg <= `EMI_WAIT_RESET;
         r.readySync1 <= 1'b1;
         r.readySync2 <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // =====================================================================
   // Pin drive and select timing.
   assign readyAct = !r.readySync2;
   assign inLead   = r.state == ext_mem_pkg::ST_LEAD;
   assign inAccess = r.state == ext_mem_pkg::ST_ACCESS;

   // A set delay bit moves the select's leading edge from the lead cycle to the access cycle.
   always_comb begin
      case (r.seg)
         ext_mem_pkg::SEG_ROM: selDelay = r.pinOpt[`EMI_PO_ROM_DLY];
         ext_mem_pkg::SEG_IO:  selDelay = r.pinOpt[`EMI_PO_IO_DLY];
         default:              selDelay = r.pinOpt[`EMI_PO_RAM_DLY];
      endcase
   end
   assign selOn = inAccess || (inLead && !selDelay);

   assign ext_rom_select_n   = !(selOn && r.seg == ext_mem_pkg::SEG_ROM);
   assign upper_ram_select_n = !(selOn && r.seg == ext_mem_pkg::SEG_RAMHI);
   assign lower_ram_select_n = !(selOn && r.seg == ext_mem_pkg::SEG_RAMLO);
   assign periphSelect_n     = !(selOn && r.seg == ext_mem_pkg::SEG_IO);
   assign any_ram_select_n   = upper_ram_select_n && lower_ram_select_n;

   // Advance shows the direction one cycle earlier, in the lead cycle.
   assign read_not_write = !(r.accWrite &&
                             (inAccess || (inLead && r.pinOpt[`EMI_PO_RW_ADV])));
   assign extDataOut     = r.wdata;
   assign extDataOe      = r.accWrite &&
                           (inAccess || (inLead && !r.pinOpt[`EMI_PO_WD_DLY]));
   assign ext_addr_out   = r.addr;

   assign coreReady      = r.state == ext_mem_pkg::ST_IDLE;
   assign coreDone       = r.done;
   assign coreRdata      = r.rdata;
   assign bootFromExtRom = r.boot;
   assign prdata         = r.prdata;
   assign pready         = 1'b1;
   assign pslverr        = r.pslverr && psel && penable;

   // =====================================================================
   // Assertions.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_idleSelects;
      coreReady |-> ext_rom_select_n && any_ram_select_n && periphSelect_n;
   endproperty
   a_idleSelects: assert property (p_idleSelects) else $error("select low while idle");

   property p_anyRam;
      any_ram_select_n == (upper_ram_select_n && lower_ram_select_n);
   endproperty
   a_anyRam: assert property (p_anyRam) else $error("combined RAM select mismatch");

   property p_xToRom;
      coreReady && coreReq && !coreSpaceY |=> ##1 !ext_rom_select_n;
   endproperty
   a_xToRom: assert property (p_xToRom) else $error("X access missed ROM select");

   property p_ramDelay;
      inLead && r.pinOpt[`EMI_PO_RAM_DLY] |-> upper_ram_select_n && lower_ram_select_n;
   endproperty
   a_ramDelay: assert property (p_ramDelay) else $error("RAM select not delayed");

   property p_rwAccess;
      inAccess |-> read_not_write == !r.accWrite;
   endproperty
   a_rwAccess: assert property (p_rwAccess) else $error("direction wrong in access");

   property p_oeWriteOnly;
      extDataOe |-> !read_not_write || (inLead && !r.pinOpt[`EMI_PO_RW_ADV]);
   endproperty
   a_oeWriteOnly: assert property (p_oeWriteOnly) else $error("data driven on read");

   property p_addrHold;
      coreReady && !$past(coreReq && coreReady) |-> $stable(ext_addr_out);
   endproperty
   a_addrHold: assert property (p_addrHold) else $error("address moved while idle");

   property p_noStretch;
      inAccess && r.cnt == 4'h0 && r.ws < `EMI_WS_READY_MIN |=> ##2 coreReady && coreDone;
   endproperty
   a_noStretch: assert property (p_noStretch) else $error("ready not ignored");

   property p_stretch;
      inAccess && r.cnt == 4'h0 && r.ws >= `EMI_WS_READY_MIN && readyAct |=> inAccess;
   endproperty
   a_stretch: assert property (p_stretch) else $error("ready did not stretch");

   property p_bootStable;
      r.bootCnt == `EMI_BOOT_SETTLE + 2'h1 && $past(r.bootCnt) == `EMI_BOOT_SETTLE + 2'h1
         |-> $stable(r.boot);
   endproperty
   a_bootStable: assert property (p_bootStable) else $error("boot source changed");

   property p_romDelay;
      inLead && r.pinOpt[`EMI_PO_ROM_DLY] |-> ext_rom_select_n;
   endproperty
   a_romDelay: assert property (p_romDelay) else $error("ROM select not delayed");

   property p_ioDelay;
      inLead && r.pinOpt[`EMI_PO_IO_DLY] |-> periphSelect_n;
   endproperty
   a_ioDelay: assert property (p_ioDelay) else $error("I/O select not delayed");

   property p_tailQuiet;
      r.state == ext_mem_pkg::ST_TAIL |->
         ext_rom_select_n && any_ram_select_n && periphSelect_n && !extDataOe;
   endproperty
   a_tailQuiet: assert property (p_tailQuiet) else $error("bus active after access");

   c_write:   cover property (coreDone && $past(r.accWrite));
   c_read:    cover property (coreDone && !$past(r.accWrite));
   c_stretch: cover property (inAccess && r.cnt == 4'h0 && readyAct ##1 inAccess);
   c_advance: cover property (inLead && r.accWrite && r.pinOpt[`EMI_PO_RW_ADV]);

endmodule
`default_nettype wire

// ==== tb/ext_mem_model.sv ====
// Behavioural external memory and I/O device on the far side of the interface pins.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
   // Clock.
   input  wire logic        mclk,
   // Pins driven by the interface.
   input  wire logic [15:0] ext_addr_out,
   input  wire logic [15:0] extDataOut,
   input  wire logic        extDataOe,
   input  wire logic        read_not_write,
   input  wire logic [4:0]  selBus_n,
   // Pins driven back.
   output logic [15:0]      extDataIn,
   output logic             readyIn_n,
   // Cycles of ready asserted per access.
   input  wire logic [7:0]  stretch
);
   logic [15:0] mem [0:63] = '{default: 16'h0};
   logic [15:0] lastBus    = 16'h0;
   logic [7:0]  readyCnt   = 8'h0;
   logic        wasSel     = 1'b0;
   logic        sel;
   logic [5:0]  idx;

   assign sel = ~&selBus_n;
   assign idx = {ext_addr_out[15:14], ext_addr_out[3:0]};

   // A bus nobody drives shows the inverse of its last value, so stale samples never match.
   always_comb begin
      if (extDataOe)
         extDataIn = extDataOut;
      else if (sel && read_not_write)
         extDataIn = mem[idx];
      else
         extDataIn = ~lastBus;
   end

   // Memory cells, bus history and the ready stretch counter.
   always @(posedge mclk) begin
      lastBus <= extDataIn;
      wasSel <= sel;
      if (sel && !read_not_write && extDataOe)
         mem[idx] <= extDataOut;
      // Low one edge after select: five cycles ahead of the end when five waits are set.
      if (sel && !wasSel)
         readyCnt <= stretch;
      else if (readyCnt != 8'h0)
         readyCnt <= readyCnt - 8'h1;
   end
   assign readyIn_n = (readyCnt == 8'h0);
endmodule
`default_nettype wire

// ==== tb/external_memory_interface_tb_top.sv ====
// Self-checking bench for the external memory interface.
`timescale 1ns/1ps
`default_nettype none
`include "ext_mem_params.svh"
module external_memory_interface_tb_top;
   // =================================================================
   // Signals.
   logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, err, bootPin;
   logic        coreReq, coreSpaceY, coreWrite, coreReady, coreDone, bootFromExtRom;
   logic        extDataOe, read_not_write, romN, hiN, loN, ioN, ramN, readyIn_n;
   logic        leadRnw, accRnw, leadOe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [15:0] coreAddr, coreWdata, coreRdata, ext_addr_out, extDataIn, extDataOut, rd;
   logic [4:0]  selN, leadAct, seenAct;
   logic [7:0]  stretch;
   int          error_cnt, total_checks, cycles, nCyc, n8;
   logic        tY [5] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
   logic [15:0] tA [5] = '{16'h0003, 16'h0005, 16'h4006, 16'h8007, 16'hc008};
   logic [4:0]  tAct [5] = '{5'h01, 5'h01, 5'h10, 5'h0c, 5'h0a};
   int          tWs [5] = '{0, 0, 5, 2, 1};

   assign selN = {ioN, ramN, loN, hiN, romN};

   // =================================================================
   // Design and far-side model.
   external_memory_interface i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .coreReq(coreReq), .coreSpaceY(coreSpaceY),
      .coreWrite(coreWrite), .coreAddr(coreAddr), .coreWdata(coreWdata),
      .coreReady(coreReady), .coreDone(coreDone), .coreRdata(coreRdata),
      .bootFromExtRom(bootFromExtRom), .ext_addr_out(ext_addr_out), .extDataIn(extDataIn),
      .extDataOut(extDataOut), .extDataOe(extDataOe), .read_not_write(read_not_write),
      .ext_rom_select_n(romN), .upper_ram_select_n(hiN), .lower_ram_select_n(loN),
      .periphSelect_n(ioN), .any_ram_select_n(ramN), .readyIn_n(readyIn_n),
      .boot_source_select(bootPin));
   ext_mem_model i_mem (.mclk(mclk), .ext_addr_out(ext_addr_out), .extDataOut(extDataOut),
      .extDataOe(extDataOe), .read_not_write(read_not_write), .selBus_n(selN),
      .extDataIn(extDataIn), .readyIn_n(readyIn_n), .stretch(stretch));

   // =================================================================
   // Clock and hang guard; a hang counts as a mismatch.
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         end_sim();
      end
   end

   // =================================================================
   // Tasks.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // APB transfer; the extra edge at the end keeps back-to-back calls off one time step.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do @(posedge mclk); while (pready !== 1'h1);
      rv = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge mclk);
   endtask

   // One core access; records pins in the lead cycle and the first access cycle.
   task automatic acc(input logic y, input logic w, input logic [15:0] a, input logic [15:0] d);
      coreReq <= 1'h1;
      coreSpaceY <= y;
      coreWrite <= w;
      coreAddr <= a;
      coreWdata <= d;
      @(posedge mclk);
      coreReq <= 1'h0;
      nCyc = 0;
      seenAct = 5'h0;
      do begin
         #1;
         if (nCyc == 0) begin
            leadAct = ~selN;
            leadRnw = read_not_write;
            leadOe = extDataOe;
         end
         if (nCyc == 1)
            accRnw = read_not_write;
         seenAct |= ~selN;
         if (coreDone === 1'h1)
            break;
         nCyc++;
         @(posedge mclk);
      end while (nCyc < 200);
      rd = coreRdata;
      check("idle sel", selN, 5'h1f);
      check("idle ready", coreReady, 1'h1);
      @(posedge mclk);
   endtask

   task automatic doReset(input logic b);
      rst_n <= 1'h0;
      bootPin <= b;
      repeat (12) @(posedge mclk);
      rst_n <= 1'h1;
      repeat (4) @(posedge mclk);
   endtask

   // =================================================================
   // Sequence: reset values, segment table, ready stretch, delay options, second reset.
   initial begin
      {mclk, psel, penable, pwrite, coreReq, coreSpaceY, coreWrite, rst_n} = 8'h0;
      {paddr, pwdata, coreAddr, coreWdata, stretch} = '0;
      bootPin = 1'h1;
      doReset(1'h1);
      check("boot", bootFromExtRom, 1'h1);
      apb(1'h0, `EMI_OFF_STATUS, 32'h0);
      check("status", rv, 32'h1);
      apb(1'h0, `EMI_OFF_PINOPT, 32'h0);
      check("pinopt", rv, 32'h0);
      apb(1'h0, 12'h010, 32'h0);
      check("unmapped", err, 1'h1);
      apb(1'h1, `EMI_OFF_WAIT, 32'h5210);
      apb(1'h0, `EMI_OFF_WAIT, 32'h0);
      check("wait", rv, 32'h5210);
      for (int i = 0; i < 5; i++) begin
         acc(tY[i], 1'h1, tA[i], 16'h5a00 + 16'(i));
         check("lead sel", leadAct, tAct[i]);
         check("lead rnw", leadRnw, 1'h1);
         check("wr rnw", accRnw, 1'h0);
         check("wr oe", leadOe, 1'h1);
         acc(tY[i], 1'h0, tA[i], 16'h0);
         check("sel", seenAct, tAct[i]);
         check("len", nCyc, tWs[i] + 4);
         check("rdata", rd, 16'h5a00 + 16'(i));
         check("rd rnw", accRnw, 1'h1);
         check("addr", ext_addr_out, tA[i]);
      end
      stretch <= 8'h8;
      acc(1'h1, 1'h0, 16'h4006, 16'h0);
      n8 = nCyc;
      check("stretch", n8 > tWs[2] + 4, 1'h1);
      stretch <= 8'h9;
      acc(1'h1, 1'h0, 16'h4006, 16'h0);
      check("stretch one", nCyc, n8 + 1);
      stretch <= 8'h8;
      acc(1'h1, 1'h0, 16'h8007, 16'h0);
      check("ignored", nCyc, 6);
      stretch <= 8'h0;
      apb(1'h1, `EMI_OFF_PINOPT, 32'h40f);
      for (int i = 0; i < 5; i++) begin
         acc(tY[i], 1'h1, tA[i], 16'h0);
         check("dly lead", leadAct, 5'h0);
         check("dly sel", seenAct, tAct[i]);
         check("adv rnw", leadRnw, 1'h0);
         check("dly oe", leadOe, 1'h0);
      end
      doReset(1'h0);
      check("boot low", bootFromExtRom, 1'h0);
      apb(1'h0, `EMI_OFF_PINOPT, 32'h0);
      check("pinopt clr", rv, 32'h0);
      end_sim();
   end
endmodule
`default_nettype wire
